// file: common/link_pkg.sv
`default_nettype none
package link_pkg;

  // ----------------------------------------------------------------
  // Register map (word index on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_CONTROL_ONE = 3'h0;
  localparam logic [2:0] ADDR_CONTROL_TWO = 3'h1;
  localparam logic [2:0] ADDR_CONTROL_THREE = 3'h2;
  localparam logic [2:0] ADDR_STATUS = 3'h3;
  localparam logic [2:0] ADDR_DATA_LOW = 3'h4;
  localparam logic [2:0] ADDR_DATA_HIGH = 3'h5;
  localparam logic [2:0] ADDR_SYNC_TIME = 3'h6;

  // Reset values of the registers, and writable bits of control one
  localparam logic [15:0] CONTROL_ONE_RESET = 16'h0000;
  localparam logic [15:0] CONTROL_ONE_WMASK = 16'hAFD7;
  localparam logic [15:0] CONTROL_TWO_RESET = 16'h0000;
  localparam logic [15:0] CONTROL_THREE_RESET = 16'h0000;
  localparam logic [15:0] DATA_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic link_enable;
    logic rsv14;
    logic idle_halt_select;
    logic rsv12;
    logic receiver_select;
    logic triggered_transmit_select;
    logic output_idle_polarity;
    logic check_nibble_enable;
    logic pause_pulse_present;
    logic short_code_external_control;
    logic rsv5;
    logic clock_divide_select;
    logic rsv3;
    logic [2:0] data_nibble_count;
  } control_one_t;

  typedef struct packed {
    logic [7:0] rsv;
    logic pause_active;
    logic [2:0] nibble_position_status;
    logic check_mismatch_flag;
    logic framing_fault_flag;
    logic line_idle_flag;
    logic sync_seen_or_send_trigger;
  } status_t;

  // ----------------------------------------------------------------
  // Timing counts in ticks, and the last prescaler count in clocks
  // ----------------------------------------------------------------
  localparam logic [10:0] SYNC_TICKS = 11'h038;
  localparam logic [10:0] NIBBLE_MIN_TICKS = 11'h00C;
  localparam logic [10:0] NIBBLE_MAX_TICKS = 11'h01B;
  localparam logic [10:0] PAUSE_MIN_TICKS = 11'h00C;
  localparam logic [10:0] LOW_PULSE_TICKS = 11'h005;
  localparam logic [10:0] FRAME_TIME_CAP = 11'h7FF;
  localparam logic [1:0] PRESCALE_LAST = 2'h3;

  // Slot positions
  localparam logic [2:0] POS_STATUS = 3'h0;
  localparam logic [2:0] POS_CHECK = 3'h7;

  // Check nibble: seed and 4-bit table, entry i at bits 4i+3..4i
  localparam logic [3:0] CRC_SEED = 4'h5;
  localparam logic [63:0] CRC_TABLE = 64'h582F_B6C1_493E_A7D0;

  // Check nibble over data nibbles 1..n, then one zero-nibble augmentation
  function automatic logic [3:0] crc_frame(input logic [23:0] d, input logic [2:0] n);
    logic [3:0] c;
    c = CRC_SEED;
    for (int i = 0; i < 6; i++) begin
      if (3'(i) < n) c = CRC_TABLE[4*c +: 4] ^ d[23 - 4*i -: 4];
    end
    c = CRC_TABLE[4*c +: 4];
    return c;
  endfunction

  // Nibble of a frame word at a slot position
  function automatic logic [3:0] slot_value(input logic [31:0] w, input logic [2:0] p);
    return (p == POS_CHECK) ? w[3:0] : w[31 - 4*p -: 4];
  endfunction

endpackage
`default_nettype wire

// file: hdl/single_edge_nibble_link.sv
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Receiver-select bit set makes a receiver, clear makes a transmitter.
// - Edge interval within sync window starts reception, sync time captured.
// - Each later interval must be a legal nibble; nibbles are stored.
// - A completed frame raises a frame-complete event.
// - Idle-halt bit set stops the block during device idle mode.
// - Transmit continuously, or one frame per software trigger.
// - Polarity bit sets transmit pin idle level: low when set.
// - Check-nibble enable verifies on receive and generates on transmit.
// - Pause-present bit selects frames with or without trailing pause.
// - Short-code bit enables external control of reception.
// - Prescaler bit divides module clock by four or by one.
// - Nibble count codes 1 to 6 select data nibbles; 0 and 7 reserved.
// - Pause flag reads one while a pause period is sent or received.
// - Position status: 7 check, 1-6 data, 0 status; held on error.
// - Check mismatch flag set when received check disagrees with data.
// - Framing flag set on nibble outside 12..27 ticks; software clears.
// - Line idle flag set after line high for sync window high count.
// - Sync/trigger bit: sync seen, enabled, or software send trigger.
// - Data words hold status, data 1..6 descending, check nibble lowest.
// - Nibble interval is its value plus twelve ticks.
// - Each frame begins with a 56-tick sync pulse.
module single_edge_nibble_link
  import link_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic [2:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [15:0] RDATA_O,
  input wire logic LINE_RX_I,
  output logic LINE_TX_O,
  output logic LINE_OE_O,
  input wire logic IDLE_MODE_I,
  input wire logic SHORT_CODE_GATE_I,
  output logic FRAME_DONE_O
);

  typedef enum logic [1:0] {
    RX_HUNT = 2'b00,
    RX_SLOT = 2'b01,
    RX_PAUSE = 2'b10
  } rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SYNC = 2'b01,
    TX_SLOT = 2'b10,
    TX_PAUSE = 2'b11
  } tx_state_t;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  control_one_t ctrl;
  logic [15:0] control_two;
  logic [15:0] control_three;
  logic [15:0] data_low;
  logic [15:0] data_high;
  logic [15:0] sync_time;
  logic mismatch_flag;
  logic framing_flag;
  logic idle_flag;
  logic trigger_flag;
  status_t wstat;
  status_t rstat;
  logic [15:0] read_value;
  logic run;
  logic rx_mode;
  logic [1:0] pre_cnt;
  logic pre_en;
  logic [2:0] rx_pipe;
  logic rx_level;
  logic [2:0] gate_pipe;
  logic gate_level;
  logic fall;
  logic [15:0] interval;
  logic [15:0] high_cnt;
  logic [16:0] acc;
  logic [16:0] acc_sum;
  logic [10:0] ticks;
  rx_state_t rx_state;
  logic [2:0] rx_pos;
  logic [31:0] rx_word;
  logic in_window;
  logic slot_ok;
  logic [10:0] ticks_less;
  logic [3:0] rx_value;
  logic rx_event;
  logic rx_done;
  logic rx_fault;
  logic [2:0] next_pos;
  logic [15:0] tdiv;
  logic tick;
  tx_state_t tx_state;
  logic [2:0] tx_pos;
  logic [10:0] sym_cnt;
  logic [10:0] sym_len;
  logic [11:0] frame_cnt;
  logic [31:0] tx_word;
  logic [31:0] tx_src;
  logic [3:0] tx_check;
  logic sym_end;
  logic tx_end;
  logic tx_load;
  logic tx_low;
  logic [2:0] next_tx_pos;
  logic [10:0] frame_cap;
  logic [11:0] elapsed;
  logic [10:0] next_pause_len;

  // ----------------------------------------------------------------
  // Mode and clocking
  // ----------------------------------------------------------------
  // Idle-halt stops the prescaler and receive events, freezing both sequencers; clearing the enable resets them
  assign run = ctrl.link_enable & ~(ctrl.idle_halt_select & IDLE_MODE_I);
  assign rx_mode = ctrl.receiver_select;

  // Prescaler restarts whenever the block is stopped
  always_ff @(posedge CLOCK_I or posedge RST_I)
    if (RST_I)
      pre_cnt <= 2'h0;
    else if (!run)
      pre_cnt <= 2'h0;
    else
      pre_cnt <= pre_cnt + 2'h1;

  assign pre_en = run & (~ctrl.clock_divide_select | (pre_cnt == PRESCALE_LAST));

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Line idles high, so the pipe resets high to avoid a false edge
  always_ff @(posedge CLOCK_I or posedge RST_I)
    if (RST_I)
    begin
      rx_pipe <= 3'h7;
      gate_pipe <= 3'h0;
    end
    else
    begin
      rx_pipe <= {rx_pipe[1:0], LINE_RX_I};
      gate_pipe <= {gate_pipe[1:0], SHORT_CODE_GATE_I};
    end

  // Level changes only once the two later stages agree
  always_ff @(posedge CLOCK_I or posedge RST_I)
    if (RST_I)
    begin
      rx_level <= 1'b1;
      gate_level <= 1'b0;
    end
    else
    begin
      if (rx_pipe[1] == rx_pipe[2]) rx_level <= rx_pipe[2];
      if (gate_pipe[1] == gate_pipe[2]) gate_level <= gate_pipe[2];
    end

  assign fall = rx_level & (rx_pipe[2:1] == 2'b00);

  // ----------------------------------------------------------------
  // Receive timing
  // ----------------------------------------------------------------
  // Interval between falling edges, in prescaled clocks, saturating; parked at
  // full while disabled so an edge from an earlier session never passes as sync
  always_ff @(posedge CLOCK_I or posedge RST_I)
    if (RST_I)
      interval <= 16'h0000;
    else if (!ctrl.link_enable)
      interval <= 16'hFFFF;
    else if (fall)
      interval <= 16'h0000;
    else if (pre_en && !(&interval))
      interval <= interval + 16'h0001;

  // High time of the line for idle detection
  always_ff @(posedge CLOCK_I or posedge RST_I)
    if (RST_I)
      high_cnt <= 16'h0000;
    else if (!rx_level)
      high_cnt <= 16'h0000;
    else if (pre_en && !(&high_cnt))
      high_cnt <= high_cnt + 16'h0001;

  always_ff @(posedge CLOCK_I or posedge RST_I)
    if (RST_I)
      idle_flag <= 1'b0;
    else
      idle_flag <= rx_mode & ctrl.link_enable & rx_level & (high_cnt >= control_two);

  // Tick count without a divider: add 56 per prescaled clock, one tick per sync
  // worth. Limitation: at most one tick per prescaled clock, so the
  // captured sync must be at least 56 prescaled clocks.
  assign acc_sum = acc + {6'h00, SYNC_TICKS};

  always_ff @(posedge CLOCK_I or posedge RST_I)
    if (RST_I)
    begin
      acc <= 17'h0_0000;
      ticks <= 11'h000;
    end
    else if (fall)
    begin
      // Half a tick of offset rounds the count to nearest
      acc <= (rx_state == RX_HUNT) ? {2'b00, interval[15:1]} : {2'b00, sync_time[15:1]};
      ticks <= 11'h000;
    end
    else if (pre_en && (acc_sum >= {1'b0, sync_time}))
    begin
      acc <= acc_sum - {1'b0, sync_time};
      if (!(&ticks)) ticks <= ticks + 11'h001;
    end
    else if (pre_en)
      acc <= acc_sum;

  // ----------------------------------------------------------------
  // Receive decode
  // ----------------------------------------------------------------
  assign in_window = (interval >= control_three) && (interval <= control_two);
  assign slot_ok = (ticks >= NIBBLE_MIN_TICKS) && (ticks <= NIBBLE_MAX_TICKS);
  assign ticks_less = ticks - NIBBLE_MIN_TICKS;
  assign rx_value = ticks_less[3:0];
  assign rx_event = run & rx_mode & fall;
  assign rx_done = rx_event & (rx_state == RX_SLOT) & slot_ok & (rx_pos == POS_CHECK);
  assign rx_fault = rx_event & (rx_state == RX_SLOT) & ~slot_ok;

  // Position after a slot; reserved counts are not trapped
  assign next_pos = (rx_pos == ctrl.data_nibble_count) ? POS_CHECK : rx_pos + 3'h1;

  always_ff @(posedge CLOCK_I or posedge RST_I)
    if (RST_I)
    begin
      rx_state <= RX_HUNT;
      rx_word <= 32'h0000_0000;
    end
    else if (!ctrl.link_enable || !rx_mode)
      rx_state <= RX_HUNT;
    else if (rx_event)
      unique case (rx_state)
        RX_HUNT:
        begin
          if (in_window && (!ctrl.short_code_external_control || gate_level))
          begin
            rx_state <= RX_SLOT;
            rx_word <= 32'h0000_0000;
          end
        end
        RX_SLOT:
        begin
          if (!slot_ok)
            rx_state <= RX_HUNT;
          else if (rx_pos == POS_CHECK)
            rx_state <= ctrl.pause_pulse_present ? RX_PAUSE : RX_HUNT;
          else
            rx_word[31 - 4*rx_pos -: 4] <= rx_value;
        end
        RX_PAUSE:
          rx_state <= RX_HUNT;
        default:
          rx_state <= RX_HUNT;
      endcase

  // Position holds where a fault struck until the next valid sync
  always_ff @(posedge CLOCK_I or posedge RST_I)
    if (RST_I)
      rx_pos <= POS_STATUS;
    else if (!ctrl.link_enable || !rx_mode)
      rx_pos <= POS_STATUS;
    else if (rx_event && (rx_state == RX_HUNT) && in_window)
      rx_pos <= POS_STATUS;
    else if (rx_event && (rx_state == RX_SLOT) && slot_ok)
      rx_pos <= (rx_pos == POS_CHECK) ? POS_STATUS : next_pos;

  // ----------------------------------------------------------------
  // Transmit timing
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I or posedge RST_I)
    if (RST_I)
      tdiv <= 16'h0000;
    else if (!ctrl.link_enable || rx_mode)
      tdiv <= 16'h0000;
    else if (pre_en)
      tdiv <= tick ? 16'h0000 : tdiv + 16'h0001;

  assign tick = pre_en & ~rx_mode & (tdiv == control_two);
  assign sym_end = tick & (sym_cnt == sym_len - 11'h001);
  assign tx_end = sym_end & (((tx_state == TX_SLOT) & (tx_pos == POS_CHECK) &
                  ~ctrl.pause_pulse_present) | (tx_state == TX_PAUSE));
  assign tx_load = (tx_state == TX_IDLE) ? (tick & (~ctrl.triggered_transmit_select | trigger_flag))
                   : (tx_end & ~ctrl.triggered_transmit_select);

  // Frame snapshot, with the check nibble generated when enabled
  assign tx_check = crc_frame({data_high[11:0], data_low[15:4]}, ctrl.data_nibble_count);
  assign tx_src = {data_high, data_low[15:4],
                   ctrl.check_nibble_enable ? tx_check : data_low[3:0]};

  assign next_tx_pos = (tx_pos == ctrl.data_nibble_count) ? POS_CHECK : tx_pos + 3'h1;

  // Pause fills the frame up to the programmed length, never below 12
  assign frame_cap = (control_three > {5'h00, FRAME_TIME_CAP}) ? FRAME_TIME_CAP : control_three[10:0];
  assign elapsed = frame_cnt + 12'h001;
  assign next_pause_len = ({1'b0, frame_cap} >= elapsed + {1'b0, PAUSE_MIN_TICKS}) ?
                          11'({1'b0, frame_cap} - elapsed) : PAUSE_MIN_TICKS;

  // ----------------------------------------------------------------
  // Transmit sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK_I or posedge RST_I)
    if (RST_I)
    begin
      tx_state <= TX_IDLE;
      tx_pos <= POS_STATUS;
      sym_cnt <= 11'h000;
      sym_len <= SYNC_TICKS;
      frame_cnt <= 12'h000;
      tx_word <= 32'h0000_0000;
    end
    else if (!ctrl.link_enable || rx_mode)
    begin
      tx_state <= TX_IDLE;
      tx_pos <= POS_STATUS;
      sym_cnt <= 11'h000;
    end
    else if (tx_load)
    begin
      tx_state <= TX_SYNC;
      tx_pos <= POS_STATUS;
      sym_cnt <= 11'h000;
      sym_len <= SYNC_TICKS;
      frame_cnt <= 12'h000;
      tx_word <= tx_src;
    end
    else if (tick && (tx_state != TX_IDLE))
    begin
      frame_cnt <= frame_cnt + 12'h001;
      sym_cnt <= sym_end ? 11'h000 : sym_cnt + 11'h001;
      if (sym_end)
        unique case (tx_state)
          TX_SYNC:
          begin
            tx_state <= TX_SLOT;
            sym_len <= {7'h00, slot_value(tx_word, POS_STATUS)} + NIBBLE_MIN_TICKS;
          end
          TX_SLOT:
          begin
            if (tx_pos != POS_CHECK)
            begin
              tx_pos <= next_tx_pos;
              sym_len <= {7'h00, slot_value(tx_word, next_tx_pos)} + NIBBLE_MIN_TICKS;
            end
            else if (ctrl.pause_pulse_present)
            begin
              tx_state <= TX_PAUSE;
              tx_pos <= POS_STATUS;
              sym_len <= next_pause_len;
            end
            else
            begin
              tx_state <= TX_IDLE;
              tx_pos <= POS_STATUS;
            end
          end
          TX_PAUSE:
            tx_state <= TX_IDLE;
          TX_IDLE:
            tx_state <= TX_IDLE;
        endcase
    end

  // Each symbol opens with a short low pulse, its falling edge marks it
  assign tx_low = (tx_state != TX_IDLE) & (sym_cnt < LOW_PULSE_TICKS);

  always_ff @(posedge CLOCK_I or posedge RST_I)
    if (RST_I)
    begin
      LINE_TX_O <= 1'b1;
      LINE_OE_O <= 1'b0;
    end
    else
    begin
      LINE_TX_O <= ~tx_low ^ ctrl.output_idle_polarity;
      LINE_OE_O <= ctrl.link_enable & ~rx_mode;
    end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  assign wstat = status_t'(WDATA_I);

  always_ff @(posedge CLOCK_I or posedge RST_I)
    if (RST_I)
    begin
      ctrl <= control_one_t'(CONTROL_ONE_RESET);
      control_two <= CONTROL_TWO_RESET;
      control_three <= CONTROL_THREE_RESET;
    end
    else if (WR_I)
      unique case (ADDR_I)
        ADDR_CONTROL_ONE: ctrl <= control_one_t'(WDATA_I & CONTROL_ONE_WMASK);
        ADDR_CONTROL_TWO: control_two <= WDATA_I;
        ADDR_CONTROL_THREE: control_three <= WDATA_I;
        default: ;
      endcase

  // Frame data: hardware commit first; software writes only in transmitter mode
  always_ff @(posedge CLOCK_I or posedge RST_I)
    if (RST_I)
    begin
      data_high <= DATA_RESET;
      data_low <= DATA_RESET;
    end
    else if (rx_done)
    begin
      data_high <= rx_word[31:16];
      data_low <= {rx_word[15:4], rx_value};
    end
    else
    begin
      if (WR_I && !rx_mode && (ADDR_I == ADDR_DATA_HIGH)) data_high <= WDATA_I;
      if (WR_I && !rx_mode && (ADDR_I == ADDR_DATA_LOW))
        data_low <= {WDATA_I[15:4], ctrl.check_nibble_enable ? data_low[3:0] : WDATA_I[3:0]};
      if (tx_load && ctrl.check_nibble_enable) data_low[3:0] <= tx_check;
    end

  always_ff @(posedge CLOCK_I or posedge RST_I)
    if (RST_I)
      sync_time <= 16'h0000;
    else if (rx_event && (rx_state == RX_HUNT) && in_window)
      sync_time <= interval;

  // Check result refreshes at every received frame end
  always_ff @(posedge CLOCK_I or posedge RST_I)
    if (RST_I)
      mismatch_flag <= 1'b0;
    else if (rx_done)
      mismatch_flag <= ctrl.check_nibble_enable &
                       (crc_frame(rx_word[27:4], ctrl.data_nibble_count) != rx_value);

  // A fault in the same cycle as a software clear is kept
  always_ff @(posedge CLOCK_I or posedge RST_I)
    if (RST_I)
      framing_flag <= 1'b0;
    else if (rx_fault)
      framing_flag <= 1'b1;
    else if (WR_I && (ADDR_I == ADDR_STATUS) && !wstat.framing_fault_flag)
      framing_flag <= 1'b0;

  // Send trigger: a software set wins over the end-of-frame clear
  always_ff @(posedge CLOCK_I or posedge RST_I)
    if (RST_I)
      trigger_flag <= 1'b0;
    else if (rx_mode || !ctrl.triggered_transmit_select)
      trigger_flag <= 1'b0;
    else if (WR_I && (ADDR_I == ADDR_STATUS) && wstat.sync_seen_or_send_trigger)
      trigger_flag <= 1'b1;
    else if (tx_end)
      trigger_flag <= 1'b0;

  always_comb
  begin
    rstat = status_t'(16'h0000);
    rstat.pause_active = rx_mode ? (rx_state == RX_PAUSE) : (tx_state == TX_PAUSE);
    rstat.nibble_position_status = rx_mode ? rx_pos : tx_pos;
    rstat.check_mismatch_flag = mismatch_flag;
    rstat.framing_fault_flag = framing_flag;
    rstat.line_idle_flag = idle_flag;
    rstat.sync_seen_or_send_trigger = rx_mode ? (rx_state != RX_HUNT) :
      (ctrl.triggered_transmit_select ? trigger_flag : ctrl.link_enable);
  end

  always_comb
  begin
    unique case (ADDR_I)
      ADDR_CONTROL_ONE: read_value = ctrl;
      ADDR_CONTROL_TWO: read_value = control_two;
      ADDR_CONTROL_THREE: read_value = control_three;
      ADDR_STATUS: read_value = rstat;
      ADDR_DATA_LOW: read_value = data_low;
      ADDR_DATA_HIGH: read_value = data_high;
      ADDR_SYNC_TIME: read_value = sync_time;
      default: read_value = 16'h0000;
    endcase
  end

  // Read data only in the cycle after the strobe, zero otherwise
  always_ff @(posedge CLOCK_I or posedge RST_I)
    if (RST_I)
      RDATA_O <= 16'h0000;
    else
      RDATA_O <= RD_I ? read_value : 16'h0000;

  always_ff @(posedge CLOCK_I or posedge RST_I)
    if (RST_I)
      FRAME_DONE_O <= 1'b0;
    else
      FRAME_DONE_O <= rx_done | (run & tx_end);

endmodule // single_edge_nibble_link
`default_nettype wire

// file: dv/single_edge_nibble_link_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module link_checker
  import link_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic [2:0] ADDR_I,
  input wire logic [15:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [15:0] RDATA_O,
  input wire logic LINE_RX_I,
  input wire logic LINE_TX_O,
  input wire logic LINE_OE_O,
  input wire logic IDLE_MODE_I,
  input wire logic SHORT_CODE_GATE_I,
  input wire logic FRAME_DONE_O
);
  control_one_t ctl;
  logic rx_q;
  logic [7:0] since_fall;
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  // Shadow of control one, so mode-dependent checks know the mode
  always_ff @(posedge CLOCK_I or posedge RST_I)
    if (RST_I) ctl <= control_one_t'(CONTROL_ONE_RESET);
    else if (WR_I && ADDR_I == ADDR_CONTROL_ONE) ctl <= control_one_t'(WDATA_I & CONTROL_ONE_WMASK);
  // Raw pin delayed one clock, for edge detection
  always_ff @(posedge CLOCK_I or posedge RST_I)
    if (RST_I) rx_q <= 1'b1;
    else rx_q <= LINE_RX_I;
  // Clocks since the pin fell; saturates so a long idle never wraps into range
  always_ff @(posedge CLOCK_I or posedge RST_I)
    if (RST_I) since_fall <= 8'hFF;
    else since_fall <= (rx_q && !LINE_RX_I) ? 8'h00 : since_fall + 8'(since_fall != 8'hFF);
  sequence s_read(logic [2:0] a);
    RD_I && ADDR_I == a;
  endsequence
  AST_RDATA_QUIET: assert property (!$past(RD_I) |-> RDATA_O == 16'h0000)
    else $error("read data not zero outside a read");
  AST_UNMAPPED_ZERO: assert property (s_read(3'h7) |=> RDATA_O == 16'h0000)
    else $error("unmapped word not zero");
  AST_CTL_READBACK: assert property (s_read(ADDR_CONTROL_ONE) |=> RDATA_O == 16'(ctl))
    else $error("control one readback wrong");
  AST_STAT_UPPER_ZERO: assert property (s_read(ADDR_STATUS) |=> RDATA_O[15:8] == 8'h00)
    else $error("status upper byte not zero");
  AST_DONE_PULSE: assert property (FRAME_DONE_O |=> !FRAME_DONE_O)
    else $error("frame done longer than one cycle");
  AST_DONE_AFTER_EDGE: assert property (FRAME_DONE_O && ctl.receiver_select |-> since_fall inside {[2:6]})
    else $error("receive frame done not tied to a line edge");
  AST_OE_OFF: assert property ((ctl.receiver_select || !ctl.link_enable)[*2] |-> !LINE_OE_O)
    else $error("output enabled while receiving or disabled");
  AST_TX_IDLE_LEVEL: assert property ((!ctl.link_enable && $stable(ctl))[*2] |-> LINE_TX_O == !ctl.output_idle_polarity)
    else $error("transmit idle level wrong");
  AST_IDLE_HALT: assert property ((IDLE_MODE_I && ctl.idle_halt_select)[*3] |-> $stable(LINE_TX_O) && !FRAME_DONE_O)
    else $error("activity while halted in idle");
endmodule // link_checker
bind single_edge_nibble_link link_checker chk_u (.*);
`default_nettype wire

// file: dv/line_sensor_model.sv
`timescale 1ns/100ps
`default_nettype none
module line_sensor_model
(
  input wire logic clk_i,
  output logic line_o
);
  // Pulled-up wire: high whenever no symbol is on it
  initial line_o = 1'b1;
  // One symbol: 5 ticks low, then high until the next falling edge
  task automatic symbol(input int ticks, input int tk);
    line_o <= 1'b0;
    repeat (5 * tk) @(posedge clk_i);
    line_o <= 1'b1;
    repeat ((ticks - 5) * tk) @(posedge clk_i);
  endtask
  // Whole frame; slot bad is stretched past the legal width to force a fault
  task automatic send(input logic [31:0] w, input int n, input int tk, input int bad, input bit pp);
    logic [3:0] v;
    symbol(56, tk);
    for (int p = 0; p <= n + 1; p++)
    begin
      v = (p == n + 1) ? w[3:0] : w[31 - 4 * p -: 4];
      symbol((p == bad) ? 30 : 12 + v, tk);
    end
    if (pp) symbol(20, tk);
    symbol(8, tk);
  endtask
endmodule // line_sensor_model
`default_nettype wire

// file: dv/tb_single_edge_nibble_link.sv
`timescale 1ns/100ps
`default_nettype none
module tb_single_edge_nibble_link
  import link_pkg::*;
;
  logic CLOCK_I = 1'b0;
  logic RST_I = 1'b1;
  logic [2:0] ADDR_I = 3'h0;
  logic [15:0] WDATA_I = 16'h0000;
  logic WR_I = 1'b0;
  logic RD_I = 1'b0;
  logic IDLE_MODE_I = 1'b0;
  logic SHORT_CODE_GATE_I = 1'b0;
  logic [15:0] RDATA_O;
  logic LINE_RX_I, LINE_TX_O, LINE_OE_O, FRAME_DONE_O, tx_q;
  int n_mismatch = 0, checks = 0, n_done = 0, n_fall = 0;
  logic [31:0] rs = 32'h49cf_2944;
  single_edge_nibble_link dut_u (.*);
  line_sensor_model sensor_u (.clk_i(CLOCK_I), .line_o(LINE_RX_I));
  // 10 MHz clock
  initial forever #50 CLOCK_I = ~CLOCK_I;
  // Done pulses and transmit falling edges, counted for later comparison
  always @(posedge CLOCK_I)
  begin
    tx_q <= LINE_TX_O;
    n_done <= n_done + int'(FRAME_DONE_O === 1'b1);
    n_fall <= n_fall + int'(tx_q === 1'b1 && LINE_TX_O === 1'b0);
  end
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  // Check nibble over data nibbles 1..n with one zero-nibble augment
  function automatic logic [3:0] exp_check(input logic [31:0] w, input int n);
    logic [3:0] c;
    c = CRC_SEED;
    for (int i = 1; i <= n; i++) c = CRC_TABLE[4 * c +: 4] ^ w[31 - 4 * i -: 4];
    return CRC_TABLE[4 * c +: 4];
  endfunction
  // Status, data 1..n and check nibble; unused slots are not defined
  function automatic logic [31:0] msk(input int n);
    return (32'hFFFF_FFFF << (28 - 4 * n)) | 32'h0000_000F;
  endfunction
  task automatic stop_test();
    if (n_mismatch == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge CLOCK_I);
    {ADDR_I, WDATA_I, WR_I} <= {a, d, 1'b1};
    @(posedge CLOCK_I);
    WR_I <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge CLOCK_I);
    {ADDR_I, RD_I} <= {a, 1'b1};
    @(posedge CLOCK_I);
    RD_I <= 1'b0;
    @(negedge CLOCK_I);
    d = RDATA_O;
  endtask
  initial
  begin
    logic [31:0] w, x, ew, em;
    logic [15:0] d, h;
    logic mm;
    int n, md, tk, pre, s, p, k0;
    repeat (10) @(posedge CLOCK_I);
    RST_I <= 1'b0;
    for (int a = 0; a < 8; a++)
    begin
      rd(3'(a), d);
      chk("reset word", 0, d);
    end
    wr(ADDR_CONTROL_ONE, 16'hFFFF);
    rd(ADDR_CONTROL_ONE, d);
    chk("control one", CONTROL_ONE_WMASK, d);
    // Receive: count codes 1 to 6, good, bad-check and framing-fault frames
    for (int k = 0; k < 18; k++)
    begin
      n = k % 6 + 1;
      md = k / 6;
      w = rnd();
      x = rnd();
      tk = x[2] ? 4 : 2;
      pre = x[2] ? 4 : 1;
      s = 56 * tk / pre;
      w[3:0] = exp_check(w, n) ^ 4'(md == 1);
      p = (md == 2) ? int'(x[10:8]) % (n + 2) : 99;
      wr(ADDR_CONTROL_ONE, 16'h0000);
      wr(ADDR_STATUS, 16'h0000);
      wr(ADDR_CONTROL_TWO, 16'(s * 6 / 5));
      wr(ADDR_CONTROL_THREE, 16'(s * 4 / 5));
      wr(ADDR_CONTROL_ONE, 16'h8800 | {7'h0, x[0], x[1], 2'b00, x[2], 1'b0, 3'(n)});
      k0 = n_done;
      @(posedge CLOCK_I);
      {IDLE_MODE_I, SHORT_CODE_GATE_I} <= x[4:3];
      sensor_u.send(w, n, tk, p, x[1]);
      repeat ((s * 6 / 5 + 10) * pre) @(posedge CLOCK_I);
      if (md != 2) {ew, em, mm} = {w, msk(n), (md == 1) && x[0]};
      chk("done count", k0 + int'(md != 2), n_done);
      rd(ADDR_DATA_HIGH, h);
      rd(ADDR_DATA_LOW, d);
      chk("frame word", ew & em, {h, d} & em);
      rd(ADDR_STATUS, d);
      chk("status", {(md != 2) ? 3'h0 : (p == n + 1) ? 3'h7 : 3'(p), mm, md == 2, 1'b1}, d[6:1]);
      rd(ADDR_SYNC_TIME, d);
      chk("sync time", 1, d + 1 - s < 2);
    end
    // Triggered transmit of one frame, stretched by an idle halt
    w = rnd();
    wr(ADDR_CONTROL_ONE, 16'h0000);
    wr(ADDR_DATA_HIGH, w[31:16]);
    wr(ADDR_DATA_LOW, w[15:0]);
    wr(ADDR_CONTROL_TWO, 16'h0001);
    wr(ADDR_CONTROL_ONE, 16'hA503);
    {k0, p} = {n_fall, n_done};
    wr(ADDR_STATUS, 16'h0001);
    rd(ADDR_STATUS, d);
    chk("trigger bit", 1, d[0]);
    chk("output enable", 1, LINE_OE_O);
    @(posedge CLOCK_I);
    IDLE_MODE_I <= 1'b1;
    repeat (100) @(posedge CLOCK_I);
    IDLE_MODE_I <= 1'b0;
    for (int i = 0; i < 4000 && n_done == p; i++) @(posedge CLOCK_I);
    chk("tx done", p + 1, n_done);
    rd(ADDR_DATA_LOW, d);
    chk("tx check", exp_check(w, 3), d[3:0]);
    rd(ADDR_STATUS, d);
    chk("trigger end", 0, d[0]);
    repeat (600) @(posedge CLOCK_I);
    chk("tx edges", k0 + 6, n_fall);
    stop_test();
  end
endmodule // tb_single_edge_nibble_link
`default_nettype wire
